/* rtl/axsu_defines.svh */
// Constants of the arithmetic extension shift and transfer unit.
// Assumes inclusion by bare name from package and top module.
`ifndef AXSU_DEFINES_SVH
`define AXSU_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave
// ----------------------------------------------------------------
`define AXSU_OFF_INSTR  8'h00
`define AXSU_OFF_ACC    8'h04
`define AXSU_OFF_MQ     8'h08
`define AXSU_OFF_LINK   8'h0C
`define AXSU_OFF_SC     8'h10
`define AXSU_OFF_STAT   8'h14

// ----------------------------------------------------------------
// Widths, reset values and instruction fields (LSB index)
// ----------------------------------------------------------------
`define AXSU_WORD_W     18
`define AXSU_SC_W       6
`define AXSU_RST_WORD   18'h00000
`define AXSU_RST_SC     6'h00
`define AXSU_CLASS_HI   17
`define AXSU_CLASS_LO   15
`define AXSU_CLASS_VAL  3'h6
`define AXSU_B_OAC      14
`define AXSU_B_SIGN_TO_LINK     13
`define AXSU_B_CLQ      12
`define AXSU_B_ABS      11
`define AXSU_B_EXT_ACC_CLEAR     10
`define AXSU_B_OMQ      9
`define AXSU_SEL_HI     8
`define AXSU_SEL_LO     6
`define AXSU_CNT_HI     5
`define AXSU_CNT_LO     0
`define AXSU_OSC_LO     0

// ----------------------------------------------------------------
// Timing: figures in ns, cycle counts derived at 100 MHz
// ----------------------------------------------------------------
`define AXSU_CLK_NS     10
`define AXSU_CTRL_NS    1750
`define AXSU_SETUP_NS   2750
`define AXSU_STEP_NS    125
`define AXSU_CTRL_CYC   ((`AXSU_CTRL_NS + `AXSU_CLK_NS - 1) / `AXSU_CLK_NS)
`define AXSU_SETUP_CYC  ((`AXSU_SETUP_NS + `AXSU_CLK_NS - 1) / `AXSU_CLK_NS)
`define AXSU_STEP_CYC   ((`AXSU_STEP_NS + `AXSU_CLK_NS - 1) / `AXSU_CLK_NS)
`define AXSU_TMR_W      16

`endif

/* rtl/axsu_pkg.sv */
// Types of the arithmetic extension shift and transfer unit.
// Assumes the defines header is on the include path.
`include "axsu_defines.svh"

package axsu_pkg;

	// ------------------------------------------------------------
	// Sequencer states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		AXSU_IDLE  = 4'b0001,
		AXSU_CTRL  = 4'b0010,
		AXSU_SETUP = 4'b0100,
		AXSU_STEP  = 4'b1000
	} axsu_state_t;

	// ------------------------------------------------------------
	// Shift selector field codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		AXSU_SH_NONE = 3'h0,
		AXSU_SH_LRS  = 3'h1,
		AXSU_SH_LLS  = 3'h2,
		AXSU_SH_ALS  = 3'h3,
		AXSU_SH_OSC  = 3'h4
	} axsu_shift_t;

	// Architectural state moved by one control evaluation
	typedef struct packed {
		logic [`AXSU_WORD_W-1:0] acc;
		logic [`AXSU_WORD_W-1:0] mq;
		logic                    link;
	} axsu_regs_t;

endpackage

/* rtl/axsu_pace.sv */
// Down-counting pacer that marks the end of a timed phase.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/10ps
`include "axsu_defines.svh"

module axsu_pace
	import axsu_pkg::*;
#(
	parameter int TW = `AXSU_TMR_W
)(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          load,
	input  wire logic [TW-1:0] load_val,
	output logic               done
);

	logic [TW-1:0] cnt;

	// ------------------------------------------------------------
	// Counter: done marks the last cycle of a phase of load_val
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= '0;
		end else if (load) begin
			cnt <= load_val;
		end else if (cnt != '0) begin
			cnt <= cnt - 1'b1;
		end
	end

	// Combinational so the sequencer acts on the very edge; not gated
	// by load, since load is itself decoded from done (no loop)
	assign done = (cnt == {{(TW-1){1'b0}}, 1'b1});

endmodule

/* rtl/axsu_top.sv */
// Arithmetic extension shift and transfer unit, AXI4-Lite slave.
// Assumes aclk at 100 MHz and a master on the same clock.
// Function
// RL1: Control operation bits combine by OR and all act in one execution.
// RL2: Load step count clears accumulator then puts counter in bits 12-17; the code ORs sc into those bits and does not clear.
// RL3: Accumulator to quotient copies accumulator, accumulator unchanged; the code ORs the accumulator into the quotient.
// RL4: Quotient to accumulator copies quotient, quotient unchanged; the code ORs the quotient into the accumulator.
// RL5: Sign magnitude: bit 0 to link, then complement if it was one.
// RL6: Code 653002 loads quotient from accumulator and returns it back.
// RL7: Step counter loads minus count, increments per step, stops at zero.
// RL8: Long right shift moves the 36-bit pair right by the count.
// RL9: Right step: acc 17 to quotient 0, quotient 17 lost, link in.
// RL10: Left step: quotient 0 to acc 17, acc 0 lost, link to quotient 17.
// RL11: Accumulator left shift feeds link into bit 17, bit 0 lost.
// RL12: Combined functions run in fixed order, control before shift.
// RL13: Signed right shift copies sign to link, then long right shift.
// RL14: Signed long left copies sign to link; count zero to 36.
// RL15: Signed accumulator left copies sign to link; count zero to 18.
// RL16: Transfer and sign operations take a fixed 1.75 us.
// RL17: Quotient register is 18 bits, beside step counter and shifter.
// RL18: Accumulator clear zeroes accumulator and leaves the link.
// RL19: Decoder must not pair accumulator clear with accumulator shift; the code runs both, clearing the accumulator before the shift.
// RL20: Shift time is a fixed setup plus one step period per bit.
`timescale 1ns/10ps
`include "axsu_defines.svh"

module axsu_top
	import axsu_pkg::*;
#(
	parameter int CTRL_CYC  = `AXSU_CTRL_CYC,
	parameter int SETUP_CYC = `AXSU_SETUP_CYC,
	parameter int STEP_CYC  = `AXSU_STEP_CYC
)(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             busy
);

	localparam int W  = `AXSU_WORD_W;
	localparam int SW = `AXSU_SC_W;
	localparam int TW = `AXSU_TMR_W;

	axsu_state_t   state;
	axsu_shift_t   sh_kind;
	logic [W-1:0]  acc;
	logic [W-1:0]  mq;          // RL17 width from the word size
	logic          link;
	logic [SW-1:0] sc;
	logic [W-1:0]  instr;
	logic [7:0]    aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	logic          aw_held;
	logic          w_held;
	logic          wr_go;
	logic          start;
	logic          tmr_load;
	logic [TW-1:0] tmr_val;
	logic          tmr_done;
	logic [SW-1:0] next_sc;
	axsu_regs_t    ctl;

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	// Shift selector of an instruction word
	function automatic axsu_shift_t shift_of(input logic [W-1:0] ins);
		logic [2:0] f;
		f = ins[`AXSU_SEL_HI:`AXSU_SEL_LO];
		case (f)
			3'h1:    shift_of = AXSU_SH_LRS;
			3'h2:    shift_of = AXSU_SH_LLS;
			3'h3:    shift_of = AXSU_SH_ALS;
			3'h4:    shift_of = AXSU_SH_OSC;
			default: shift_of = AXSU_SH_NONE;
		endcase
	endfunction

	// Register offset known to the map
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `AXSU_OFF_INSTR) || (a == `AXSU_OFF_ACC) ||
			(a == `AXSU_OFF_MQ) || (a == `AXSU_OFF_LINK) ||
			(a == `AXSU_OFF_SC) || (a == `AXSU_OFF_STAT);
	endfunction

	// Control functions in their fixed event order; each stage sees
	// the previous one, so any OR of bits is one coherent execution.
	function automatic axsu_regs_t control(
		input logic [W-1:0]  ins,
		input logic [W-1:0]  a,
		input logic [W-1:0]  q,
		input logic          l,
		input logic [SW-1:0] s
	);
		axsu_regs_t r;
		logic       sgn;
		r.acc = a;
		r.mq = q;
		r.link = l;
		sgn = a[W-1];
		if (ins[`AXSU_B_CLQ]) begin
			r.mq = '0;                                // RL1
		end
		if (ins[`AXSU_B_SIGN_TO_LINK]) begin
			r.link = sgn;                             // RL5
		end
		if (ins[`AXSU_B_OAC]) begin
			r.mq = r.mq | r.acc;                      // RL3
		end
		if (ins[`AXSU_B_ABS] && sgn) begin
			r.acc = ~r.acc;                           // RL5
		end
		if (ins[`AXSU_B_EXT_ACC_CLEAR]) begin
			r.acc = '0;                               // RL18
		end
		if (ins[`AXSU_B_OMQ]) begin
			r.acc = r.acc | r.mq;                     // RL4
		end
		if (shift_of(ins) == AXSU_SH_OSC) begin
			r.acc[SW-1:0] = r.acc[SW-1:0] | s;        // RL2
		end
		control = r;
	endfunction

	// ------------------------------------------------------------
	// AXI4-Lite write channels
	// ------------------------------------------------------------

	// Address and data are taken in either order and held until
	// both are present and the previous response has gone.
	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign wr_go         = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && !aw_held) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && !w_held) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held <= 1'b0;
		end
	end

	// Response: unmapped offsets answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(aw_addr) ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// An instruction write while busy is dropped; software polls
	// the status word first, the unit has no queue.
	assign start = wr_go && (aw_addr == `AXSU_OFF_INSTR) &&
		(state == AXSU_IDLE) && (w_strb[2:0] == 3'h7);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr <= `AXSU_RST_WORD;
		end else if (start) begin
			instr <= w_data[W-1:0];
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'h0;
			s_axi_rdata  <= 32'h00000000;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
			case (s_axi_araddr)
				`AXSU_OFF_INSTR: s_axi_rdata <= {14'h0000, instr};
				`AXSU_OFF_ACC:   s_axi_rdata <= {14'h0000, acc};
				`AXSU_OFF_MQ:    s_axi_rdata <= {14'h0000, mq};
				`AXSU_OFF_LINK:  s_axi_rdata <= {31'h00000000, link};
				`AXSU_OFF_SC:    s_axi_rdata <= {26'h0000000, sc};
				`AXSU_OFF_STAT:  s_axi_rdata <= {31'h00000000, busy};
				default:         s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Phase timer
	// ------------------------------------------------------------
	axsu_pace #(
		.TW       (TW)
	) u_pace (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.load     (tmr_load),
		.load_val (tmr_val),
		.done     (tmr_done)
	);

	assign sh_kind = shift_of(instr);
	assign busy    = (state != AXSU_IDLE);
	assign next_sc = sc + 1'b1;
	assign ctl     = control(w_data[W-1:0], acc, mq, link, sc);

	// Timer reload: start of a control, setup, or next step phase
	always_comb begin
		tmr_load = 1'b0;
		tmr_val  = '0;
		if (start) begin
			tmr_load = 1'b1;
			if (shift_of(w_data[W-1:0]) inside {AXSU_SH_NONE,
				AXSU_SH_OSC}) begin
				tmr_val = TW'(CTRL_CYC);                 // RL16
			end else begin
				tmr_val = TW'(SETUP_CYC);                // RL20
			end
		end else if (tmr_done && (state == AXSU_SETUP) && sc != '0) begin
			tmr_load = 1'b1;
			tmr_val  = TW'(STEP_CYC);                    // RL20
		end else if (tmr_done && (state == AXSU_STEP) &&
			next_sc != '0) begin
			tmr_load = 1'b1;
			tmr_val  = TW'(STEP_CYC);
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= AXSU_IDLE;
		end else begin
			case (state)
				AXSU_IDLE: begin
					if (start && tmr_val == TW'(CTRL_CYC) &&
						shift_of(w_data[W-1:0]) inside
						{AXSU_SH_NONE, AXSU_SH_OSC}) begin
						state <= AXSU_CTRL;
					end else if (start) begin
						state <= AXSU_SETUP;
					end
				end
				AXSU_CTRL: begin
					if (tmr_done) begin
						state <= AXSU_IDLE;
					end
				end
				AXSU_SETUP: begin
					if (tmr_done) begin
						state <= (sc == '0) ? AXSU_IDLE : AXSU_STEP;
					end
				end
				AXSU_STEP: begin
					if (tmr_done && next_sc == '0) begin
						state <= AXSU_IDLE;                  // RL7
					end
				end
				default: state <= AXSU_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Datapath: control stage at start, then one shift per step
	// ------------------------------------------------------------

	// Software loads of the data registers only land while idle,
	// so a running shift is never torn by a bus write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc  <= `AXSU_RST_WORD;
			mq   <= `AXSU_RST_WORD;
			link <= 1'b0;
			sc   <= `AXSU_RST_SC;
		end else if (start) begin
			// Control functions precede any shift          RL12
			acc  <= ctl.acc;                             // RL6
			mq   <= ctl.mq;
			link <= ctl.link;                            // RL13
			if (!(shift_of(w_data[W-1:0]) inside {AXSU_SH_NONE,
				AXSU_SH_OSC})) begin
				// Minus count, counted up to zero          RL7
				sc <= SW'(~w_data[`AXSU_CNT_HI:`AXSU_CNT_LO] + 1'b1);
			end
		end else if (state == AXSU_STEP && tmr_done) begin
			sc <= next_sc;                               // RL7
			case (sh_kind)
				AXSU_SH_LRS: begin
					// Pair shifts right, link refills top      RL8
					{acc, mq} <= {link, acc, mq[W-1:1]};     // RL9
				end
				AXSU_SH_LLS: begin
					// Pair shifts left, link fills the end     RL14
					{acc, mq} <= {acc[W-2:0], mq, link};     // RL10
				end
				AXSU_SH_ALS: begin
					acc <= {acc[W-2:0], link};               // RL11 RL15
				end
				default: acc <= acc;
			endcase
		end else if (wr_go && state == AXSU_IDLE) begin
			case (aw_addr)
				`AXSU_OFF_ACC: begin
					acc <= w_data[W-1:0];
				end
				`AXSU_OFF_MQ: begin
					mq <= w_data[W-1:0];
				end
				`AXSU_OFF_LINK: begin
					link <= w_data[0];
				end
				`AXSU_OFF_SC: begin
					sc <= w_data[SW-1:0];
				end
				default: sc <= sc;
			endcase
		end
	end

endmodule

/* sim/axsu_props.sv */
// Checker of handshakes and execution time at the unit's ports.
// Assumes it is bound into axsu_top and sees its ports only.
`timescale 1ns/10ps

module axsu_props
#(
	parameter int CTRL_CYC  = 175,
	parameter int SETUP_CYC = 275,
	parameter int STEP_CYC  = 13
)(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        busy
);
	logic [15:0] len;
	logic [17:0] wd;
	logic [17:0] op;
	logic        shf;
	int          want;

	// Busy cycles so far; reset to zero between operations
	always_ff @(posedge aclk) begin
		if (!aresetn || !busy) begin
			len <= 16'h0000;
		end else begin
			len <= len + 16'h0001;
		end
	end
	// Last written word, frozen as the running op when busy starts
	always_ff @(posedge aclk) begin
		if (s_axi_wvalid && s_axi_wready) begin
			wd <= s_axi_wdata[17:0];
		end
		if (busy && len == 16'h0000) begin
			op <= wd;
		end
	end
	// Expected busy length from the selector and count fields
	assign shf  = op[8:6] inside {3'h1, 3'h2, 3'h3};
	assign want = shf ? SETUP_CYC + STEP_CYC * int'(op[5:0]) : CTRL_CYC;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid lost");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid lost");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read not answered");
	read_excl_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready while rvalid");
	unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr > 8'h14 |=> s_axi_rresp == 2'h2 &&
		s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	start_resp_a: assert property ($rose(busy) |-> $rose(s_axi_bvalid)
		&& s_axi_bresp == 2'h0) else $error("start without response");
	busy_min_a: assert property ($rose(busy) |-> busy [*3])
		else $error("busy too short");
	ctrl_time_a: assert property ($fell(busy) && !shf |->
		len == want[15:0]) else $error("control time wrong");
	shift_time_a: assert property ($fell(busy) && shf |->
		len == want[15:0]) else $error("shift time wrong");

	cover property ($fell(busy) && shf && op[5:0] == 6'h24);
	cover property ($fell(busy) && !shf);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind axsu_top axsu_props #(
	.CTRL_CYC(CTRL_CYC),
	.SETUP_CYC(SETUP_CYC),
	.STEP_CYC(STEP_CYC)
) i_axsu_props (.*);

/* sim/axsu_master.sv */
// Bus master model for the processor side of the unit.
// Assumes one clock; a transfer starts one edge after the call.
`timescale 1ns/10ps

module axsu_master (
	input  wire logic        aclk,
	output logic [7:0]       s_axi_awaddr,
	output logic [2:0]       s_axi_awprot,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic [2:0]       s_axi_arprot,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// Every other transfer raises its answer ready late, so the
	// slave must hold a pending response
	logic lazy = 1'b0;

	// Idle bus at time zero; strobes always whole words
	initial begin
		{s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end

	// One transfer; the edge wait first keeps a gap after the last one
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q,
		output logic [1:0] r, output logic ok);
		int k;
		ok = 1'b0;
		q = 32'h0;
		r = 2'h3;
		lazy = ~lazy;
		@(posedge aclk);
		if (wr) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= !lazy;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= !lazy;
		end
		for (k = 0; k < 400 && !ok; k++) begin
			@(posedge aclk);
			// Released payload shows a changed value, not the old one
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
			// Answer taken only at an edge with valid and ready both high
			if (wr ? s_axi_bvalid : s_axi_rvalid) begin
				if (wr ? s_axi_bready : s_axi_rready) begin
					q = s_axi_rdata;
					r = wr ? s_axi_bresp : s_axi_rresp;
					s_axi_bready <= 1'b0;
					s_axi_rready <= 1'b0;
					ok = 1'b1;
				end else if (wr) begin
					s_axi_bready <= 1'b1;
				end else begin
					s_axi_rready <= 1'b1;
				end
			end
		end
	endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench: random loads, every operation, then readback.
// Assumes the unit, its bound checker and the bus master model.
`timescale 1ns/10ps

module tb_top;
	import axsu_pkg::*;
	logic        aclk, aresetn, busy;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready;
	logic        s_axi_arvalid, s_axi_arready, l, sh;
	int          err_total, n_tests, seed, it, j, k;
	logic [17:0] a, q, ins;
	logic [17:0] tbl [16];
	logic [5:0]  s;
	logic [42:0] e;

	axsu_top #(.CTRL_CYC(3), .SETUP_CYC(3), .STEP_CYC(2)) i_axsu_top (.*);
	axsu_master i_axsu_master (.*);

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// A lost answer ends the run at once
	task automatic bus(input logic wr, input logic [7:0] ad,
		input logic [31:0] d);
		logic ok;
		i_axsu_master.xfer(wr, ad, d, rd, rr, ok);
		if (!ok) begin
			err_total++;
			end_sim();
		end
	endtask
	// Poll status; a unit that never goes idle fails the run
	task automatic wait_idle();
		for (k = 0; k < 100; k++) begin
			bus(1'b0, 8'h14, 32'h0);
			if (rd[0] === 1'b0) return;
		end
		err_total++;
		end_sim();
	endtask
	// Expected state after one instruction, in the unit's event order
	function automatic logic [42:0] model(input logic [17:0] i, a, q,
		input logic l, input logic [5:0] s);
		logic sg;
		int   n;
		sg = a[17];
		if (i[12]) q = 18'h00000;
		if (i[13]) l = sg;
		if (i[14]) q = q | a;
		if (i[11] && sg) a = ~a;
		if (i[10]) a = 18'h00000;
		if (i[9]) a = a | q;
		if (i[8:6] == 3'h4) a[5:0] = a[5:0] | s;
		if (i[8:6] inside {3'h1, 3'h2, 3'h3}) begin
			for (n = 0; n < int'(i[5:0]); n++) begin
				case (i[8:6])
				3'h1: {a, q} = {l, a, q[17:1]};
				3'h2: {a, q} = {a[16:0], q, l};
				default: a = {a[16:0], l};
				endcase
			end
			s = 6'h00;
		end
		return {a, q, l, s};
	endfunction

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Main sequence
	initial begin
		err_total = 0;
		n_tests = 0;
		seed = 13;
		aresetn = 1'b0;
		// No pairing of accumulator clear with accumulator shift
		tbl = '{18'h30500, 18'h35000, 18'h30600, 18'h32800, 18'h35600,
			18'h30100, 18'h30040, 18'h30080, 18'h300C0, 18'h32040,
			18'h32080, 18'h320C0, 18'h30240, 18'h31080, 18'h308C0,
			18'h30480};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, then unmapped places refused
		for (j = 1; j < 7; j++) begin
			bus(1'b0, 8'(j * 4), 32'h0);
			chk("reset value", rd, 32'h0);
			chk("read resp", {30'h0, rr}, j == 6 ? 32'h2 : 32'h0);
		end
		bus(1'b1, 8'h1C, 32'h1);
		chk("unmapped write", {30'h0, rr}, 32'h2);
		for (it = 0; it < 48; it++) begin
			ins = tbl[it % 16];
			sh = ins[8:6] inside {3'h1, 3'h2, 3'h3};
			if (sh && it < 16) ins[5:0] = ins[7:6] == 2'h3 ? 6'h12 : 6'h24;
			if (sh && it >= 32)
				ins[5:0] = 6'({$random(seed)} % (ins[7:6] == 2'h3 ? 19 : 37));
			a = 18'($random(seed));
			q = 18'($random(seed));
			l = 1'($random(seed));
			s = 6'($random(seed));
			if (it == 3) a[17] = 1'b1;
			bus(1'b1, 8'h04, {14'h0, a});
			bus(1'b1, 8'h08, {14'h0, q});
			bus(1'b1, 8'h0C, {31'h0, l});
			bus(1'b1, 8'h10, {26'h0, s});
			e = model(ins, a, q, l, s);
			bus(1'b1, 8'h00, {14'h0, ins});
			chk("start resp", {30'h0, rr}, 32'h0);
			// A second instruction while busy must be dropped
			if (sh && ins[5:0] > 6'h03) begin
				bus(1'b0, 8'h14, 32'h0);
				chk("busy", rd, 32'h1);
				bus(1'b1, 8'h00, 32'h30400);
			end
			wait_idle();
			bus(1'b0, 8'h04, 32'h0);
			chk("acc", rd, {14'h0, e[42:25]});
			bus(1'b0, 8'h08, 32'h0);
			chk("quotient", rd, {14'h0, e[24:7]});
			bus(1'b0, 8'h0C, 32'h0);
			chk("link", rd, {31'h0, e[6]});
			bus(1'b0, 8'h10, 32'h0);
			chk("step count", rd, {26'h0, e[5:0]});
		end
		end_sim();
	end
endmodule
